//--- rtl/iqf_pkg.sv
// shared constants and carrier types for the iq input interpolator front end
package iqf_pkg;
    localparam int WORD_W = 14;
    localparam int TW_W = 32;
    localparam int CIC_W = 6;
    localparam int NPROF = 4;
    localparam int HB_FACTOR = 4;
    localparam int QM_FACTOR = 2;
    localparam int HB_TAPS = 7;
    localparam int ICIC_TAPS = 3;
    localparam int COEF_W = 16;
    localparam int COEF_SH = 15;
    // register indices (byte address = 4 * index)
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_CTRL06 = 8'h06;
    localparam logic [7:0] REG_CIC = 8'h07;
    localparam logic [7:0] REG_TW0 = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_ACC = 8'h11;
    localparam int ICIC_BYP_BIT = 0;
    localparam int LOCKQ_BIT = 1;
    localparam int CICBYP_BIT = 6;
    localparam logic [1:0] MODE_QUAD = 2'h0;
    localparam logic [1:0] MODE_TONE = 2'h1;
    localparam logic [1:0] MODE_IDAC = 2'h2;
    localparam logic [CIC_W-1:0] CIC_RST = 6'h02;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // half-band 0.5 symmetric kernel, odd phase taps (Q15), linear phase
    localparam logic signed [COEF_W-1:0] HB_C0 = 16'sh4D00;
    localparam logic signed [COEF_W-1:0] HB_C1 = -16'sh1300;
    localparam logic signed [COEF_W-1:0] HB_C2 = 16'sh0600;
    localparam logic signed [COEF_W-1:0] HB_C3 = -16'sh0100;
    // inverse cic 3-tap symmetric kernel (Q15)
    localparam logic signed [COEF_W-1:0] IC_EDGE = -16'sh0A00;
    // one bit wider: centre gain sits above unity, edges pull it back
    localparam logic signed [COEF_W:0] IC_MID = 17'sh0_9400;
    typedef struct packed {
        logic signed [WORD_W-1:0] i;
        logic signed [WORD_W-1:0] q;
    } iqf_pair_type;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } iqf_bus_type;
endpackage

//--- rtl/iqf_front_end.sv
// parallel port capture, word clock, tuning transfer and 4x interpolator
`timescale 1ns/100ps
`default_nettype none
module iqf_front_end
    import iqf_pkg::*;
#(
    parameter int DIV_MIN = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // parallel data port pins
    input wire logic [WORD_W-1:0] port_data,
    input wire logic transmit_gate,
    input wire logic word_clock_or_update_pin_i,
    output logic word_clock_or_update_pin_o,
    output logic word_clock_or_update_pin_oe,
    input wire logic profile_select_0,
    input wire logic profile_select_1,
    input wire logic pll_lock,
    // outputs toward cic and synthesizer
    output iqf_pair_type hb_out,
    output logic hb_valid,
    output logic [TW_W-1:0] acc_tuning_word,
    output logic acc_load,
    output logic icic_power_on
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) rst_sync_q <= 2'b00;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // pin synchronisers, everything sampled on sys_clk
    logic [WORD_W-1:0] data_m_q, data_s_q;
    logic [5:0] pin_m_q, pin_s_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_m_q <= '0;
            data_s_q <= '0;
            pin_m_q <= '0;
            pin_s_q <= '0;
        end else begin
            data_m_q <= port_data;
            data_s_q <= data_m_q;
            pin_m_q <= {pll_lock, profile_select_1, profile_select_0,
                        word_clock_or_update_pin_i, transmit_gate, 1'b0};
            pin_s_q <= pin_m_q;
        end
    end
    wire gate_s = pin_s_q[1];
    wire fud_s = pin_s_q[2];
    wire [1:0] psel_s = pin_s_q[4:3];
    wire lock_s = pin_s_q[5];

    // registers
    logic [1:0] mode_q;
    logic [1:0] ctrl06_q;
    logic [CIC_W:0] cic_q;
    logic [TW_W-1:0] tw_q [NPROF];
    wire wr_mode = reg_wr && reg_addr == REG_MODE;
    wire wr_06 = reg_wr && reg_addr == REG_CTRL06;
    wire wr_cic = reg_wr && reg_addr == REG_CIC;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_QUAD;
            ctrl06_q <= '0;
            cic_q <= {1'b0, CIC_RST};
        end else begin
            if (wr_mode) mode_q <= reg_wdata[1:0];
            if (wr_06) ctrl06_q <= reg_wdata[1:0];
            if (wr_cic) cic_q <= reg_wdata[CIC_W:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        for (int p = 0; p < NPROF; p++) begin
            if (reg_wr && reg_addr == REG_TW0 + 8'(p)) tw_q[p] <= reg_wdata;
        end
    end
    wire is_quad = mode_q == MODE_QUAD;
    wire is_tone = mode_q == MODE_TONE;
    wire is_idac = mode_q == MODE_IDAC;
    wire cic_one = cic_q[CICBYP_BIT] || cic_q[CIC_W-1:0] < 6'h02;
    wire icic_byp = ctrl06_q[ICIC_BYP_BIT] || cic_one;

    // word clock divider: cic rate * 4, times 2 in quadrature, never below DIV_MIN
    logic [9:0] div_cnt_q;
    logic wclk_q;
    wire [9:0] cic_eff = cic_one ? 10'h001 : {4'h0, cic_q[CIC_W-1:0]};
    wire [9:0] div_base = 10'(cic_eff * HB_FACTOR);
    wire [9:0] div_tot = is_quad ? 10'(div_base * QM_FACTOR) : div_base;
    wire [9:0] div_n = div_tot < 10'(DIV_MIN) ? 10'(DIV_MIN) : div_tot;
    wire div_wrap = div_cnt_q >= div_n - 10'h001;
    wire wclk_rise = div_wrap; // the pin goes high two cycles later
    wire half = div_cnt_q == (div_n >> 1) - 10'h001;
    wire wclk_en = !ctrl06_q[LOCKQ_BIT] || lock_s;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= '0;
            wclk_q <= 1'b0;
        end else begin
            div_cnt_q <= div_wrap ? 10'h000 : div_cnt_q + 10'h001;
            if (div_wrap) wclk_q <= wclk_en;
            else if (half) wclk_q <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_clock_or_update_pin_o <= 1'b0;
            word_clock_or_update_pin_oe <= 1'b0;
        end else begin
            word_clock_or_update_pin_o <= wclk_q && !is_tone;
            word_clock_or_update_pin_oe <= !is_tone;
        end
    end

    // capture on word clock rising edge, data set up ahead of it
    logic cap_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) cap_q <= 1'b0;
        else cap_q <= wclk_rise && wclk_en && !is_tone;
    end
    logic phase_q;
    logic signed [WORD_W-1:0] i_hold_q;
    iqf_pair_type pair_q;
    logic pair_v_q;
    logic flush_ph_q;
    wire signed [WORD_W-1:0] word_in = data_s_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 1'b0;
            i_hold_q <= '0;
            pair_q <= '0;
            pair_v_q <= 1'b0;
            flush_ph_q <= 1'b0;
        end else begin
            pair_v_q <= 1'b0;
            if (!gate_s || !is_quad) phase_q <= 1'b0;
            if (cap_q && is_idac) begin
                pair_q <= '{i: word_in, q: '0};
                pair_v_q <= 1'b1;
            end else if (cap_q && is_quad && !gate_s) begin
                pair_q <= '0;
                // zeros still move at pair rate, one per two words
                pair_v_q <= flush_ph_q;
                flush_ph_q <= !flush_ph_q;
                i_hold_q <= '0;
            end else if (cap_q && is_quad) begin
                phase_q <= !phase_q;
                if (!phase_q) i_hold_q <= word_in;
                else begin
                    pair_q <= '{i: i_hold_q, q: word_in};
                    pair_v_q <= 1'b1;
                end
            end
        end
    end

    // tuning word transfer
    logic fud_d1_q;
    logic [1:0] psel_d1_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fud_d1_q <= 1'b0;
            psel_d1_q <= '0;
            acc_tuning_word <= '0;
            acc_load <= 1'b0;
        end else begin
            fud_d1_q <= fud_s;
            psel_d1_q <= psel_s;
            acc_load <= 1'b0;
            if ((is_tone && fud_s && !fud_d1_q) || psel_s != psel_d1_q) begin
                acc_tuning_word <= tw_q[psel_s];
                acc_load <= 1'b1;
            end
        end
    end

    // inverse cic: symmetric 3-tap FIR, clock-gated by enable
    function automatic logic signed [WORD_W-1:0] sat(
        input logic signed [WORD_W+COEF_W+2:0] v);
        logic signed [WORD_W+COEF_W+2:0] s;
        s = v >>> COEF_SH;
        if (s > (2**(WORD_W-1))-1) sat = {1'b0, {(WORD_W-1){1'b1}}};
        else if (s < -(2**(WORD_W-1))) sat = {1'b1, {(WORD_W-1){1'b0}}};
        else sat = s[WORD_W-1:0];
    endfunction
    iqf_pair_type ic_d1_q, ic_d2_q, ic_out_q;
    logic ic_v_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ic_d1_q <= '0;
            ic_d2_q <= '0;
            ic_out_q <= '0;
            ic_v_q <= 1'b0;
        end else begin
            ic_v_q <= pair_v_q;
            if (pair_v_q && icic_byp) begin
                ic_out_q <= pair_q; // taps frozen: no toggling
            end else if (pair_v_q) begin
                ic_d1_q <= pair_q;
                ic_d2_q <= ic_d1_q;
                ic_out_q.i <= sat(IC_EDGE * (pair_q.i + ic_d2_q.i)
                    + IC_MID * ic_d1_q.i);
                ic_out_q.q <= sat(IC_EDGE * (pair_q.q + ic_d2_q.q)
                    + IC_MID * ic_d1_q.q);
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) icic_power_on <= 1'b0;
        else icic_power_on <= !icic_byp;
    end

    // two cascaded half-band stages; each emits even (centre tap) then odd phase
    // polyphase form keeps symmetric taps, so linear phase
    localparam int NST = 2;
    iqf_pair_type hb_line_q [NST][HB_TAPS+1];
    iqf_pair_type hb_o_q [NST];
    logic [NST-1:0] hb_v_q;
    logic [1:0] hb_wait_q [NST];
    function automatic logic signed [WORD_W-1:0] hb_odd(
        input logic signed [WORD_W-1:0] a0, a1, a2, a3,
        input logic signed [WORD_W-1:0] b0, b1, b2, b3);
        hb_odd = sat(HB_C0 * (a0 + b0) + HB_C1 * (a1 + b1)
            + HB_C2 * (a2 + b2) + HB_C3 * (a3 + b3));
    endfunction
    for (genvar s = 0; s < NST; s++) begin : g_hb
        wire in_v = s == 0 ? ic_v_q : hb_v_q[0];
        iqf_pair_type in_w;
        assign in_w = s == 0 ? ic_out_q : hb_o_q[0];
        // first stage spaces its phases so the second keeps pace
        localparam logic [1:0] HOLD = 2'(NST - s);
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                for (int k = 0; k <= HB_TAPS; k++) hb_line_q[s][k] <= '0;
                hb_o_q[s] <= '0;
                hb_v_q[s] <= 1'b0;
                hb_wait_q[s] <= 2'h0;
            end else begin
                hb_v_q[s] <= 1'b0;
                if (in_v) begin
                    hb_line_q[s][0] <= in_w;
                    for (int k = 1; k <= HB_TAPS; k++)
                        hb_line_q[s][k] <= hb_line_q[s][k-1];
                    hb_o_q[s] <= hb_line_q[s][3]; // centre tap, gain one
                    hb_v_q[s] <= 1'b1;
                    hb_wait_q[s] <= HOLD;
                end else if (hb_wait_q[s] == 2'h1) begin
                    hb_o_q[s].i <= hb_odd(hb_line_q[s][3].i,
                        hb_line_q[s][2].i, hb_line_q[s][1].i,
                        hb_line_q[s][0].i, hb_line_q[s][4].i,
                        hb_line_q[s][5].i, hb_line_q[s][6].i,
                        hb_line_q[s][7].i);
                    hb_o_q[s].q <= hb_odd(hb_line_q[s][3].q,
                        hb_line_q[s][2].q, hb_line_q[s][1].q,
                        hb_line_q[s][0].q, hb_line_q[s][4].q,
                        hb_line_q[s][5].q, hb_line_q[s][6].q,
                        hb_line_q[s][7].q);
                    hb_v_q[s] <= 1'b1;
                    hb_wait_q[s] <= 2'h0;
                end else if (hb_wait_q[s] != 2'h0) begin
                    hb_wait_q[s] <= hb_wait_q[s] - 2'h1;
                end
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hb_out <= '0;
            hb_valid <= 1'b0;
        end else begin
            hb_out <= hb_o_q[1];
            hb_valid <= hb_v_q[1];
        end
    end

    // read port: data one cycle after strobe
    logic [31:0] rd_mux;
    assign rd_mux = reg_addr == REG_MODE ? {30'h0, mode_q}
        : reg_addr == REG_CTRL06 ? {30'h0, ctrl06_q}
        : reg_addr == REG_CIC ? {25'h0, cic_q}
        : reg_addr == REG_STAT ? {27'h0, lock_s, gate_s, phase_q,
                                  icic_byp, !is_tone}
        : reg_addr == REG_ACC ? acc_tuning_word
        : (reg_addr >= REG_TW0 && reg_addr < REG_TW0 + 8'(NPROF))
            ? tw_q[reg_addr[1:0]] : RD_ZERO;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) reg_rdata <= RD_ZERO;
        else reg_rdata <= reg_rd ? rd_mux : RD_ZERO;
    end

    a_tone_pin_off: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        is_tone |=> !word_clock_or_update_pin_oe)
        else $error("pin driven in single tone");
    a_pin_drives: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !is_tone |=> word_clock_or_update_pin_oe)
        else $error("pin not driven outside single tone");
    a_fud_load: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        is_tone && fud_s && !fud_d1_q |=> acc_load)
        else $error("update edge did not load tuning word");
    a_psel_load: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        psel_s != psel_d1_q |=> acc_load &&
            acc_tuning_word == $past(tw_q[psel_s]))
        else $error("profile change did not apply");
    a_gate_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cap_q && is_quad && !gate_s |=> pair_q == '0)
        else $error("gate low did not flush zeros");
    a_idac_qzero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        pair_v_q && $past(is_idac) |-> pair_q.q == '0)
        else $error("q path not zero in dac mode");
    a_dac_word: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cap_q && is_idac |=> pair_v_q && pair_q.i == $past(word_in))
        else $error("dac capture did not load i path");
    a_i_first: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cap_q && is_quad && gate_s && !phase_q |=> !pair_v_q && phase_q)
        else $error("i word did not wait for its q word");
    a_icic_bypass: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cic_one ##1 cic_one |-> !icic_power_on)
        else $error("inverse cic not bypassed at rate one");
    // stage one phases two apart, stage two four in a row
    sequence s_hb0_pair;
        ##1 hb_v_q[0] ##1 !hb_v_q[0] ##1 hb_v_q[0];
    endsequence
    sequence s_hb1_burst;
        ##2 hb_v_q[1] [*4];
    endsequence
    a_hb_fourx: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ic_v_q |-> s_hb0_pair)
        else $error("half-band stage did not double rate");
    a_hb_out_four: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ic_v_q |-> s_hb1_burst)
        else $error("interpolator did not give four samples");
    a_lock_gate: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ctrl06_q[LOCKQ_BIT] && !lock_s |=> !cap_q)
        else $error("capture while lock qualify blocks clock");
    a_lock_pin_low: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ctrl06_q[LOCKQ_BIT] && !lock_s && !wclk_q |=> !wclk_q)
        else $error("word clock rose without lock");
endmodule // iqf_front_end
`default_nettype wire

//--- bench/iqf_source.sv
// baseband data source model driving the parallel word port
`timescale 1ns/100ps
`default_nettype none
module iqf_source
    import iqf_pkg::*;
(
    // word clock as seen on the shared pin
    input wire logic word_clk,
    // bench controls
    input wire logic run,
    input wire logic dac_mode,
    input wire logic [WORD_W-1:0] i_word,
    input wire logic [WORD_W-1:0] q_word,
    // port pins
    output logic [WORD_W-1:0] port_data,
    output logic transmit_gate
);
    logic next_q;

    initial begin
        port_data = '0;
        transmit_gate = 1'b0;
        next_q = 1'b0;
    end

    // falling edge change keeps the word settled at the rise
    always @(negedge word_clk) begin
        if (next_q) begin
            port_data <= q_word;
            next_q <= 1'b0;
        end else if (run) begin
            transmit_gate <= 1'b1;
            // dc words sit deep inside the flat passband
            port_data <= i_word;
            next_q <= !dac_mode;
        end else begin
            // gate only drops once a whole pair is out
            transmit_gate <= 1'b0;
            // released bus shows the inverted last word, then toggles back to it
            port_data <= ~port_data;
        end
    end
endmodule // iqf_source
`default_nettype wire

//--- bench/iqf_front_end_bench.sv
// self-checking bench for the iq input front end
`timescale 1ns/100ps
`default_nettype none
module iqf_front_end_bench
    import iqf_pkg::*;
;
    localparam int RATE = 3;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [WORD_W-1:0] port_data;
    logic transmit_gate;
    logic pin_o, pin_oe, pin;
    logic upd_drv = 1'b0;
    logic [1:0] prof = 2'h0;
    logic pll_lock = 1'b1;
    iqf_pair_type hb_out;
    logic hb_valid, acc_load, icic_power_on;
    logic [TW_W-1:0] acc_tuning_word;
    logic run = 1'b0;
    logic dac_mode = 1'b0;
    logic [WORD_W-1:0] i_word = 14'h0000;
    logic [WORD_W-1:0] q_word = 14'h0000;
    int mismatches = 0;
    int samples_checked = 0;
    int n, nv, ni, nq, ng, k;

    // wire level of the shared pin from both parties
    assign pin = pin_oe ? pin_o : upd_drv;

    always #50 sys_clk = ~sys_clk;

    iqf_front_end #(.DIV_MIN(8)) dut (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .port_data(port_data),
        .transmit_gate(transmit_gate),
        .word_clock_or_update_pin_i(pin),
        .word_clock_or_update_pin_o(pin_o),
        .word_clock_or_update_pin_oe(pin_oe),
        .profile_select_0(prof[0]),
        .profile_select_1(prof[1]),
        .pll_lock(pll_lock),
        .hb_out(hb_out),
        .hb_valid(hb_valid),
        .acc_tuning_word(acc_tuning_word),
        .acc_load(acc_load),
        .icic_power_on(icic_power_on)
    );

    iqf_source src (
        .word_clk(pin),
        .run(run),
        .dac_mode(dac_mode),
        .i_word(i_word),
        .q_word(q_word),
        .port_data(port_data),
        .transmit_gate(transmit_gate)
    );

    function automatic logic [31:0] tw(input int p);
        return {8'h5A, 8'(p), 16'hC3A5};
    endfunction

    task check(input string nm, input logic [31:0] seen,
               input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // let the registered effects land
        repeat (3) @(posedge sys_clk);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(nm, reg_rdata, e);
    endtask

    // cycles between two rises of the shared pin, 0 if none
    task period(output int cnt);
        int j, r;
        logic p;
        cnt = 0;
        r = 0;
        p = 1'b1;
        for (j = 0; j < 400 && r < 2; j++) begin
            @(posedge sys_clk);
            #1;
            if (r == 1) cnt++;
            if (pin === 1'b1 && p === 1'b0) r++;
            p = pin;
        end
    endtask

    task watch(input int cyc);
        int j;
        nv = 0;
        ni = 0;
        nq = 0;
        ng = 0;
        for (j = 0; j < cyc; j++) begin
            @(posedge sys_clk);
            #1;
            if (hb_valid === 1'b1) begin
                nv++;
                if (hb_out.i !== '0) ni++;
                if (hb_out.q !== '0) nq++;
                if (hb_out.q[WORD_W-1] === 1'b1) ng++;
            end
        end
    endtask

    task wait_load(input logic [31:0] e);
        int j;
        // step past the edge that may still show the last load pulse
        @(posedge sys_clk);
        #1;
        for (j = 0; j < 30 && acc_load !== 1'b1; j++) begin
            @(posedge sys_clk);
            #1;
        end
        check("acc_load", acc_load, 1'b1);
        check("acc_tuning_word", acc_tuning_word, e);
    endtask

    task close_out;
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        close_out;
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(REG_MODE, {30'h0, MODE_QUAD}, "mode");
        rd(REG_CIC, {26'h0, CIC_RST}, "cic rate");
        rd(8'h3F, RD_ZERO, "unmapped");
        check("icic on", icic_power_on, 1'b1);
        wr(REG_CTRL06, 32'h0000_0001);
        check("icic bypass", icic_power_on, 1'b0);
        wr(REG_CTRL06, 32'h0000_0000);
        wr(REG_CIC, 32'h0000_0040);
        check("icic cic off", icic_power_on, 1'b0);
        wr(REG_CIC, 32'h0000_0001);
        check("icic rate1", icic_power_on, 1'b0);
        wr(REG_CIC, 32'h0000_003F);
        check("icic rate63", icic_power_on, 1'b1);
        wr(REG_CIC, 32'(RATE));
        check("icic rate3", icic_power_on, 1'b1);
        check("pin driven", pin_oe, 1'b1);
        period(n);
        check("quad period", n, RATE * 8);
        wr(REG_CTRL06, 32'h0000_0002);
        pll_lock <= 1'b0;
        repeat (6) @(posedge sys_clk);
        period(n);
        check("gated clock", n, 0);
        pll_lock <= 1'b1;
        period(n);
        check("locked clock", n, RATE * 8);
        // gate low: junk on the port must not reach the filters
        q_word <= 14'h2000;
        watch(300);
        check("idle zeros", ni + nq, 0);
        run <= 1'b1;
        watch(480);
        check("i from first word", ni, 0);
        check("q negative", ng > 0, 1'b1);
        check("quad x4", nv >= 36 && nv <= 44, 1'b1);
        run <= 1'b0;
        // zero pairs must clear both half-band delay lines
        repeat (1000) @(posedge sys_clk);
        dac_mode <= 1'b1;
        i_word <= 14'h0800;
        wr(REG_MODE, {30'h0, MODE_IDAC});
        period(n);
        check("dac period", n, RATE * 4);
        run <= 1'b1;
        watch(480);
        check("q held zero", nq, 0);
        check("i path fed", ni > 0, 1'b1);
        check("dac x4", nv >= 152 && nv <= 168, 1'b1);
        run <= 1'b0;
        for (k = 0; k < NPROF; k++) begin
            wr(REG_TW0 + 8'(k), tw(k));
        end
        wr(REG_MODE, {30'h0, MODE_TONE});
        check("pin released", pin_oe, 1'b0);
        upd_drv <= 1'b1;
        wait_load(tw(0));
        @(posedge sys_clk);
        upd_drv <= 1'b0;
        prof <= 2'h2;
        wait_load(tw(2));
        rd(REG_ACC, tw(2), "acc word");
        close_out;
    end
endmodule // iqf_front_end_bench
`default_nettype wire
